// >>> inc/odm_consts.svh
// odm_consts.svh: offsets, command codes, reset values and timing of the octal mode control
// assumes inclusion by bare name from the package and the design modules
`ifndef ODM_CONSTS_SVH
`define ODM_CONSTS_SVH
`define ODM_NCH 8
`define ODM_NPAR 4
`define ODM_ADDR_W 8
`define ODM_ADDR_CMD 8'h00
`define ODM_ADDR_STATUS 8'h04
`define ODM_ADDR_MODE 8'h08
`define ODM_CMD_STBY 2'h0
`define ODM_CMD_INP 2'h1
`define ODM_CMD_ON 2'h2
`define ODM_CMD_OFF 2'h3
`define ODM_CMD_RST 16'hffff
`define ODM_CMD_ALL_STBY 16'h0000
`define ODM_TER_RST 1'b1
`define ODM_OL_DELAY_US 15
`define ODM_CLK_MHZ 250
`define ODM_OL_CNT_W 12
`endif

// >>> inc/odm_pkg.sv
// odm_pkg: types of the octal mode control
// assumes odm_consts.svh on the include path
`include "odm_consts.svh"
package odm_pkg;
	typedef enum logic [2:0] {
		ODM_ST_UNDERVOLTAGE_LOCKOUT = 3'h0,
		ODM_ST_LOWIQ = 3'h1,
		ODM_ST_NORMAL = 3'h2,
		ODM_ST_LIMP = 3'h3
	} odm_mode_t;
	typedef struct packed {
		logic vdd_ok;
		logic analog_supply_ok;
		logic enable;
		logic limp_home_input;
		logic [`ODM_NPAR-1:0] par_in;
		logic [`ODM_NCH-1:0] overload;
		logic [`ODM_NCH-1:0] overtemp;
	} odm_pins_t;
	typedef struct packed {
		logic [`ODM_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} odm_bus_t;
	typedef struct packed {
		odm_mode_t mode;
		logic [2*`ODM_NCH-1:0] cmd;
		logic frame_error_flag;
		logic pwrup;
		logic en_d;
		logic [`ODM_NCH-1:0] out;
		logic [`ODM_NCH-1:0] diag;
		logic low_iq;
		logic [31:0] rdata;
	} odm_state_t;
	typedef struct packed {
		logic [`ODM_OL_CNT_W-1:0] cnt;
		logic ol;
		logic ot;
	} odm_chan_t;
endpackage : odm_pkg

// >>> hdl/odm_sync.sv
// odm_sync: three-stage synchroniser for asynchronous pin levels
// assumes i_d comes from outside the i_clk domain; o_q changes once stages two and three agree
`timescale 1ns/1ps
module odm_sync #(
	parameter int unsigned W = 24
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] q;
	} odm_sync_st_t;
	odm_sync_st_t s_ff;
	odm_sync_st_t nxt_s;
	always_comb begin
		nxt_s = s_ff;
		nxt_s.ff1 = i_d;
		nxt_s.ff2 = s_ff.ff1;
		nxt_s.ff3 = s_ff.ff2;
		// the first stage is never compared, only passed on
		nxt_s.q = (s_ff.ff2 & s_ff.ff3) | (s_ff.q & (s_ff.ff2 | s_ff.ff3));
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign o_q = s_ff.q;
endmodule : odm_sync

// >>> hdl/odm_chan.sv
// odm_chan: overload filter and fault latches of one output channel
// assumes i_on is the registered driver state and the sensors are already synchronised
`timescale 1ns/1ps
`include "odm_consts.svh"
module odm_chan #(
	parameter logic [`ODM_OL_CNT_W-1:0] DLY_CYC = `ODM_OL_CNT_W'(`ODM_OL_DELAY_US * `ODM_CLK_MHZ)
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_on,
	input wire logic i_overload,
	input wire logic i_overtemp,
	input wire logic i_clr,
	output logic o_fault_ol,
	output logic o_fault_ot
);
	localparam logic [`ODM_OL_CNT_W-1:0] DLY_M1 = DLY_CYC - `ODM_OL_CNT_W'(1);
	odm_pkg::odm_chan_t s_ff;
	odm_pkg::odm_chan_t nxt_s;
	logic set_ol;
	always_comb begin
		nxt_s = s_ff;
		set_ol = 1'b0;
		if (i_on && i_overload && !s_ff.ol) begin
			set_ol = (s_ff.cnt == DLY_M1);
			nxt_s.cnt = s_ff.cnt + `ODM_OL_CNT_W'(1);
		end else begin
			nxt_s.cnt = '0;
		end
		nxt_s.ol = set_ol | (s_ff.ol & !i_clr);
		nxt_s.ot = i_overtemp | (s_ff.ot & !i_clr);
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign o_fault_ol = s_ff.ol;
	assign o_fault_ot = s_ff.ot;
	a_ol_filter_delay: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$rose(s_ff.ol) |-> $past(s_ff.cnt) == DLY_M1)
		else $error("overload latched before the filter delay");
	a_ol_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		s_ff.ol && !i_clr |=> s_ff.ol)
		else $error("overload fault dropped without a clear");
endmodule : odm_chan

// >>> hdl/odm_ctrl.sv
// odm_ctrl: channel mode and protection control of an eight-channel low-side switch
// assumes supply-good, enable, limp-home, parallel and sensor levels arrive asynchronously;
// the register port is a single-cycle strobe bus on i_clk with read data one cycle later
// Operation
// - overload switches channel off, latched
// - overload filtered by fifteen microsecond delay
// - detect shorts at turn-on and later
// - standby command or power reset clears faults
// - rising enable restores all defaults, except in limp, where it is ignored
// - per-channel commands only when powered, enabled
// - reset: commands all ones, status zero, error set
// - both supplies needed, limp needs analog only
// - power-up off mode without diagnostic current
// - decode 11 off, 10 on, 00 standby, 01 input
// - lockout keeps outputs off, exit by pins
// - enable and limp low gives low current
// - global standby: off, no diagnostics, low current
// - input n drives outputs n and n+4
// - channel commanded off ignores its input
// - parallel-mode faults stay until serial clear
// - limp: outputs 1-4 follow inputs, 5-8 off
// - limp: sensing active, commands ignored
// - leaving limp resets, off or low current
// - limp to off sets frame error flag
// - analog supply loss locks out, faults cleared
// - enable or limp rising powers up
// - standby clears own channel, others clear all
// - two command and two status bits per channel
// - valid command clears frame error flag
// - overtemperature latches only its own channel
`timescale 1ns/1ps
`include "odm_consts.svh"
module odm_ctrl #(
	parameter int unsigned NCH = `ODM_NCH,
	parameter logic [`ODM_OL_CNT_W-1:0] OL_DLY_CYC = `ODM_OL_CNT_W'(`ODM_OL_DELAY_US * `ODM_CLK_MHZ)
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire odm_pkg::odm_pins_t i_pins,
	input wire odm_pkg::odm_bus_t i_bus,
	output logic [31:0] o_rdata,
	output logic [NCH-1:0] o_output_channel,
	output logic [NCH-1:0] o_diag_en,
	output logic o_low_iq,
	output logic [2:0] o_mode
);
	localparam odm_pkg::odm_state_t ST_RST = '{
		mode: odm_pkg::ODM_ST_UNDERVOLTAGE_LOCKOUT,
		cmd: `ODM_CMD_RST,
		frame_error_flag: `ODM_TER_RST,
		pwrup: 1'b1,
		en_d: 1'b0,
		out: '0,
		diag: '0,
		low_iq: 1'b1,
		rdata: '0
	};

	odm_pkg::odm_state_t s_ff;
	odm_pkg::odm_state_t nxt_s;
	odm_pkg::odm_pins_t pin_s;
	logic por_ok;
	logic en_rise;
	logic rst_all;
	logic cmd_wr;
	logic [NCH-1:0] fault_ol;
	logic [NCH-1:0] fault_ot;
	logic [NCH-1:0] fault;
	logic [NCH-1:0] drv;
	logic [NCH-1:0] diag;
	logic [NCH-1:0] clr;
	logic [2*NCH-1:0] stat;

	odm_sync #(
		.W($bits(odm_pkg::odm_pins_t))
	) u_sync (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_d(i_pins),
		.o_q(pin_s)
	);

	assign por_ok = pin_s.analog_supply_ok & (pin_s.vdd_ok | pin_s.limp_home_input);
	assign en_rise = pin_s.enable & !s_ff.en_d;

	assign cmd_wr = i_bus.wr && (i_bus.addr == `ODM_ADDR_CMD) && por_ok
		&& (s_ff.mode == odm_pkg::ODM_ST_NORMAL) && pin_s.enable && !pin_s.limp_home_input;

	assign rst_all = !por_ok
		|| (s_ff.mode == odm_pkg::ODM_ST_UNDERVOLTAGE_LOCKOUT)
		|| (s_ff.mode == odm_pkg::ODM_ST_LOWIQ)
		|| (s_ff.mode == odm_pkg::ODM_ST_NORMAL && !pin_s.enable && !pin_s.limp_home_input)
		|| (s_ff.mode == odm_pkg::ODM_ST_LIMP && !pin_s.limp_home_input);

	assign fault = fault_ol | fault_ot;

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic [1:0] code;
		logic par;
		assign code = s_ff.cmd[2*i +: 2];
		assign par = pin_s.par_in[i % `ODM_NPAR];

		always_comb begin
			drv[i] = 1'b0;
			diag[i] = 1'b0;
			case (s_ff.mode)
				odm_pkg::ODM_ST_NORMAL: begin
					drv[i] = !fault[i] && ((code == `ODM_CMD_ON)
						|| (code == `ODM_CMD_INP && par));
					diag[i] = (code == `ODM_CMD_OFF) && !s_ff.pwrup;
				end
				odm_pkg::ODM_ST_LIMP: begin
					drv[i] = (i < `ODM_NPAR) && par && !fault[i];
				end
				default: begin
					drv[i] = 1'b0;
				end
			endcase
		end

		assign clr[i] = rst_all
			|| (s_ff.mode == odm_pkg::ODM_ST_NORMAL && code == `ODM_CMD_STBY);

		odm_chan #(
			.DLY_CYC(OL_DLY_CYC)
		) u_chan (
			.i_clk(i_clk),
			.i_rst_b(i_rst_b),
			.i_on(s_ff.out[i]),
			.i_overload(pin_s.overload[i]),
			.i_overtemp(pin_s.overtemp[i]),
			.i_clr(clr[i]),
			.o_fault_ol(fault_ol[i]),
			.o_fault_ot(fault_ot[i])
		);

		assign stat[2*i] = fault_ol[i];
		assign stat[2*i+1] = fault_ot[i];
	end

	always_comb begin
		nxt_s = s_ff;
		nxt_s.en_d = pin_s.enable;
		nxt_s.out = drv;
		nxt_s.diag = diag;
		if (!por_ok) begin
			nxt_s.mode = odm_pkg::ODM_ST_UNDERVOLTAGE_LOCKOUT;
			nxt_s.cmd = `ODM_CMD_RST;
			nxt_s.frame_error_flag = `ODM_TER_RST;
			nxt_s.pwrup = 1'b1;
		end else begin
			case (s_ff.mode)
				odm_pkg::ODM_ST_UNDERVOLTAGE_LOCKOUT: begin
					nxt_s.cmd = `ODM_CMD_RST;
					nxt_s.frame_error_flag = `ODM_TER_RST;
					nxt_s.pwrup = 1'b1;
					if (pin_s.limp_home_input) begin
						nxt_s.mode = odm_pkg::ODM_ST_LIMP;
					end else if (pin_s.enable) begin
						nxt_s.mode = odm_pkg::ODM_ST_NORMAL;
					end else begin
						nxt_s.mode = odm_pkg::ODM_ST_LOWIQ;
					end
				end
				odm_pkg::ODM_ST_LOWIQ: begin
					nxt_s.cmd = `ODM_CMD_RST;
					nxt_s.frame_error_flag = `ODM_TER_RST;
					nxt_s.pwrup = 1'b1;
					if (pin_s.limp_home_input) begin
						nxt_s.mode = odm_pkg::ODM_ST_LIMP;
					end else if (en_rise) begin
						nxt_s.mode = odm_pkg::ODM_ST_NORMAL;
					end
				end
				odm_pkg::ODM_ST_NORMAL: begin
					if (pin_s.limp_home_input) begin
						nxt_s.mode = odm_pkg::ODM_ST_LIMP;
					end else if (!pin_s.enable) begin
						nxt_s.mode = odm_pkg::ODM_ST_LOWIQ;
						nxt_s.cmd = `ODM_CMD_RST;
						nxt_s.frame_error_flag = `ODM_TER_RST;
						nxt_s.pwrup = 1'b1;
					end else if (cmd_wr) begin
						nxt_s.cmd = i_bus.wdata[2*NCH-1:0];
						nxt_s.frame_error_flag = 1'b0;
						nxt_s.pwrup = 1'b0;
					end
				end
				odm_pkg::ODM_ST_LIMP: begin
					if (!pin_s.limp_home_input) begin
						nxt_s.cmd = `ODM_CMD_RST;
						nxt_s.pwrup = 1'b1;
						nxt_s.frame_error_flag = 1'b1;
						nxt_s.mode = pin_s.enable ? odm_pkg::ODM_ST_NORMAL
							: odm_pkg::ODM_ST_LOWIQ;
					end
				end
				default: begin
					nxt_s.mode = odm_pkg::ODM_ST_UNDERVOLTAGE_LOCKOUT;
				end
			endcase
		end
		nxt_s.low_iq = (nxt_s.mode == odm_pkg::ODM_ST_LOWIQ)
			|| (nxt_s.mode == odm_pkg::ODM_ST_NORMAL
			&& nxt_s.cmd == `ODM_CMD_ALL_STBY);
		// read data stand for one cycle only; faults stay readable in limp
		nxt_s.rdata = '0;
		if (i_bus.rd) begin
			case (i_bus.addr)
				`ODM_ADDR_CMD: nxt_s.rdata = {16'h0000, s_ff.cmd};
				`ODM_ADDR_STATUS: nxt_s.rdata = {15'h0000, s_ff.frame_error_flag, stat};
				`ODM_ADDR_MODE: nxt_s.rdata = {16'h0000, s_ff.diag, 3'h0, s_ff.low_iq,
					s_ff.pwrup, s_ff.mode};
				default: nxt_s.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			s_ff <= ST_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_rdata = s_ff.rdata;
	assign o_output_channel = s_ff.out;
	assign o_diag_en = s_ff.diag;
	assign o_low_iq = s_ff.low_iq;
	assign o_mode = s_ff.mode;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence seq_limp_exit;
		s_ff.mode == odm_pkg::ODM_ST_LIMP && por_ok && !pin_s.limp_home_input
			&& pin_s.enable;
	endsequence
	sequence seq_off_with_error;
		s_ff.mode == odm_pkg::ODM_ST_NORMAL && s_ff.frame_error_flag && s_ff.cmd == `ODM_CMD_RST;
	endsequence

	a_fault_forces_off: assert property (
		(o_output_channel & $past(fault)) == '0)
		else $error("faulted channel still driven");
	a_undervoltage_lockout_all_off: assert property (
		s_ff.mode == odm_pkg::ODM_ST_UNDERVOLTAGE_LOCKOUT |=> o_output_channel == '0)
		else $error("output on in lockout");
	a_limp_upper_off: assert property (
		s_ff.mode == odm_pkg::ODM_ST_LIMP |=> o_output_channel[NCH-1:`ODM_NPAR] == '0)
		else $error("upper outputs on in limp mode");
	a_limp_lower_follow: assert property (
		s_ff.mode == odm_pkg::ODM_ST_LIMP |=>
		o_output_channel[`ODM_NPAR-1:0] == $past(pin_s.par_in & ~fault[`ODM_NPAR-1:0]))
		else $error("lower outputs do not follow inputs in limp mode");
	a_limp_cmd_ignored: assert property (
		s_ff.mode == odm_pkg::ODM_ST_LIMP && pin_s.limp_home_input && por_ok
		&& i_bus.wr |=> $stable(s_ff.cmd))
		else $error("command accepted in limp mode");
	a_limp_exit_error: assert property (
		seq_limp_exit |=> seq_off_with_error)
		else $error("limp exit did not reset and flag error");
	a_enable_rise_reset: assert property (
		s_ff.mode == odm_pkg::ODM_ST_LOWIQ && por_ok && en_rise && !pin_s.limp_home_input
		|=> seq_off_with_error ##0 s_ff.pwrup)
		else $error("enable rise did not power up with defaults");
	a_cmd_clears_error: assert property (
		cmd_wr |=> !s_ff.frame_error_flag && s_ff.cmd == $past(i_bus.wdata[2*NCH-1:0]))
		else $error("valid command did not clear the error flag");
	a_low_current_entry: assert property (
		por_ok && !pin_s.enable && !pin_s.limp_home_input
		&& s_ff.mode != odm_pkg::ODM_ST_UNDERVOLTAGE_LOCKOUT |=> s_ff.mode == odm_pkg::ODM_ST_LOWIQ)
		else $error("low current mode not entered");
	a_standby_clears: assert property (
		(s_ff.mode == odm_pkg::ODM_ST_NORMAL && s_ff.cmd[1:0] == `ODM_CMD_STBY
		&& !s_ff.out[0] && !pin_s.overtemp[0])[*2] |-> !fault[0])
		else $error("standby did not clear channel fault");
	// a driver still on in the first standby cycle may finish its count; that set wins
	a_input_pairing: assert property (
		s_ff.mode == odm_pkg::ODM_ST_NORMAL && s_ff.cmd[1:0] == `ODM_CMD_INP
		&& s_ff.cmd[9:8] == `ODM_CMD_INP && !fault[0] && !fault[4]
		|=> o_output_channel[0] == o_output_channel[4])
		else $error("paired outputs differ in input mode");
	a_off_ignores_input: assert property (
		s_ff.mode == odm_pkg::ODM_ST_NORMAL && s_ff.cmd[9:8] == `ODM_CMD_OFF
		|=> !o_output_channel[4])
		else $error("channel commanded off still driven");
	a_lowiq_all_off: assert property (
		s_ff.mode == odm_pkg::ODM_ST_LOWIQ |=> o_output_channel == '0)
		else $error("output on in low current mode");
	a_standby_low_iq: assert property (
		s_ff.mode == odm_pkg::ODM_ST_NORMAL && s_ff.cmd == `ODM_CMD_ALL_STBY |-> o_low_iq)
		else $error("global standby without reduced current");
	a_powerup_no_diag: assert property (
		s_ff.pwrup |=> o_diag_en == '0)
		else $error("diagnostic current on after power-up");
endmodule : odm_ctrl

// >>> tb/odm_load.sv
// odm_load: loads on the eight low-side outputs, each with a short that can be set
// assumes o_overload feeds the overload comparator pins of the mode control
`timescale 1ns/1ps
module odm_load (
	input wire logic [7:0] i_out,
	input wire logic [7:0] i_short,
	output logic [7:0] o_overload
);
	// short draws current
	// a shorted load draws overload current only while its switch is on
	assign o_overload = i_out & i_short;
endmodule : odm_load

// >>> tb/testbench.sv
// testbench: directed run of the octal mode control through its register port and pins
// assumes odm_ctrl with a shortened overload filter and the load model on its outputs
`timescale 1ns/1ps
module testbench;
	localparam logic [11:0] DLY = 12'h008;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	odm_pkg::odm_pins_t pins = 24'he0_0000;
	odm_pkg::odm_pins_t pins_w;
	odm_pkg::odm_bus_t bus = '0;
	logic [7:0] shrt = 8'h00;
	logic [7:0] ol;
	logic [31:0] rdata;
	logic [7:0] outs;
	logic [7:0] diag;
	logic low_iq;
	logic [2:0] mode;
	int num_errors = 0;
	int n_checks = 0;
	always #2 i_clk = ~i_clk;
	// overload comes from the load model, not from the bench
	always_comb begin
		pins_w = pins;
		pins_w.overload = ol;
	end
	odm_ctrl #(.NCH(8), .OL_DLY_CYC(DLY)) i_dut (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_pins(pins_w),
		.i_bus(bus),
		.o_rdata(rdata),
		.o_output_channel(outs),
		.o_diag_en(diag),
		.o_low_iq(low_iq),
		.o_mode(mode)
	);
	odm_load i_load (.i_out(outs), .i_short(shrt), .o_overload(ol));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// waits end 1 ns past the edge so that the edge's updates have landed
	task wt(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : wt
	task pt(input logic [2:0] m, input logic [7:0] o);
		chk(32'({mode, outs}), 32'({m, o}));
	endtask : pt
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		bus.wr <= 1'b0;
		wt(4);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata & msk, exp);
	endtask : rd
	task stop_test;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	// whole run is well under a thousand cycles
	initial begin
		wt(5000);
		num_errors++;
		stop_test();
	end
	initial begin
		wt(16);
		i_rst_b <= 1'b1;
		wt(12);
		pt(3'h2, 8'h00);
		chk(32'(diag), 32'h0000_0000);
		rd(8'h00, ALL, 32'h0000_ffff);
		rd(8'h04, ALL, 32'h0001_0000);
		rd(8'h08, 32'h0000_000f, 32'h0000_000a);
		rd(8'h0c, ALL, 32'h0000_0000);
		wr(8'h00, 32'h0000_aaaa);
		pt(3'h2, 8'hff);
		rd(8'h04, ALL, 32'h0000_0000);
		wr(8'h00, 32'h0000_ffff);
		pt(3'h2, 8'h00);
		chk(32'(diag), 32'h0000_00ff);
		// switch on into an existing short on channel 2
		shrt <= 8'h02;
		wr(8'h00, 32'h0000_aaaa);
		wt(30);
		pt(3'h2, 8'hfd);
		rd(8'h04, ALL, 32'h0000_0004);
		// a spike shorter than the filter must not latch channel 3
		shrt <= 8'h06;
		wt(4);
		shrt <= 8'h02;
		wt(30);
		pt(3'h2, 8'hfd);
		shrt <= 8'h06;
		wt(30);
		pt(3'h2, 8'hf9);
		shrt <= 8'h00;
		wt(12);
		pt(3'h2, 8'hf9);
		rd(8'h04, ALL, 32'h0000_0014);
		wr(8'h00, 32'h0000_aa82);
		rd(8'h04, ALL, 32'h0000_0000);
		wr(8'h00, 32'h0000_aaaa);
		pt(3'h2, 8'hff);
		pins.overtemp <= 8'h08;
		wt(6);
		pins.overtemp <= 8'h00;
		wt(6);
		pt(3'h2, 8'hf7);
		rd(8'h04, ALL, 32'h0000_0080);
		// channel 5 off, the rest follow inputs; channel 4 keeps its fault
		wr(8'h00, 32'h0000_5755);
		pins.par_in <= 4'h5;
		wt(12);
		pt(3'h2, 8'h45);
		pins.par_in <= 4'ha;
		wt(12);
		pt(3'h2, 8'ha2);
		wr(8'h00, 32'h0000_0000);
		pt(3'h2, 8'h00);
		chk(32'({low_iq, diag}), 32'h0000_0100);
		rd(8'h04, ALL, 32'h0000_0000);
		pins.limp_home_input <= 1'b1;
		pins.par_in <= 4'hf;
		wt(12);
		pt(3'h3, 8'h0f);
		wr(8'h00, 32'h0000_ffff);
		pt(3'h3, 8'h0f);
		shrt <= 8'h01;
		wt(30);
		shrt <= 8'h00;
		wt(12);
		pt(3'h3, 8'h0e);
		rd(8'h04, 32'h0000_00ff, 32'h0000_0001);
		pins.limp_home_input <= 1'b0;
		wt(12);
		pt(3'h2, 8'h00);
		chk(32'(diag), 32'h0000_0000);
		rd(8'h04, ALL, 32'h0001_0000);
		rd(8'h00, ALL, 32'h0000_ffff);
		pins.enable <= 1'b0;
		wt(12);
		pt(3'h1, 8'h00);
		chk(32'(low_iq), 32'h0000_0001);
		wr(8'h00, 32'h0000_aaaa);
		pt(3'h1, 8'h00);
		pins.enable <= 1'b1;
		wt(12);
		pt(3'h2, 8'h00);
		rd(8'h08, 32'h0000_000f, 32'h0000_000a);
		wr(8'h00, 32'h0000_aaaa);
		pins.vdd_ok <= 1'b0;
		wt(12);
		pt(3'h0, 8'h00);
		pins.limp_home_input <= 1'b1;
		wt(12);
		pt(3'h3, 8'h0f);
		pins.analog_supply_ok <= 1'b0;
		wt(12);
		pt(3'h0, 8'h00);
		stop_test();
	end
endmodule : testbench
